// File: tb/reset_pin_partner.sv
// Pad model of the reset line with its pull-up.
`timescale 1ns/1ps
module reset_pin_partner (
  // Device side.
  input wire logic resetPinOe,
  input wire logic resetPinOut,
  // Pad level.
  output logic resetPinIn
);
  // The pull-up wins unless the device sinks the pin.
  assign resetPinIn = (resetPinOe && !resetPinOut) ? 1'b0 : 1'b1;
endmodule : reset_pin_partner

// File: tb/voltage_monitor_status_map_chk.sv
// Port checker for the monitor status map.
`timescale 1ns/1ps
module voltage_monitor_status_map_chk
  import voltage_monitor_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  // Front end.
  input wire comparator_t comparators,
  input wire comparator_power_t comparatorPower,
  input wire logic oscTick,
  input wire logic parityError,
  input wire logic supplyGood,
  input wire logic [1:0] holdSelect,
  input wire logic sequenceRecordReady,
  // Pins.
  input wire logic sequenceEnableA,
  input wire logic sequenceEnableB,
  input wire logic resetPinIn,
  input wire logic resetPinOut,
  input wire logic resetPinOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Pin, read-back and clear-on-read relations.
  sink_only_a: assert property (resetPinOut == 1'b0)
    else $error("reset pin driven high");
  pin_level_a: assert property ($stable(resetPinIn)[*6] ##0 (regRead && regAddr == 8'h02)
    |=> regRdata[4] == $past(resetPinIn)) else $error("pin level bit wrong");
  enable_a_level_a: assert property ($stable(sequenceEnableA)[*6] ##0
    (regRead && regAddr == 8'h02) |=> regRdata[2] == $past(sequenceEnableA))
    else $error("enable a bit wrong");
  enable_b_level_a: assert property ($stable(sequenceEnableB)[*6] ##0
    (regRead && regAddr == 8'h02) |=> regRdata[3] == $past(sequenceEnableB))
    else $error("enable b bit wrong");
  off_live_a: assert property ($stable(comparators.belowOff)[*3] ##0
    (regRead && regAddr == 8'h07) |=> regRdata == {1'b0, $past(comparators.belowOff)})
    else $error("off status not live");
  ov_clear_a: assert property ((regRead && regAddr == 8'h05 && comparators.overVoltage == 7'h00)
    ##1 comparators.overVoltage == 7'h00 ##1 (regRead && regAddr == 8'h05 &&
    comparators.overVoltage == 7'h00) |=> regRdata == 8'h00) else $error("ov not cleared");
  uv_clear_a: assert property ((regRead && regAddr == 8'h06 && comparators.underVoltage == 7'h00)
    ##1 comparators.underVoltage == 7'h00 ##1 (regRead && regAddr == 8'h06 &&
    comparators.underVoltage == 7'h00) |=> regRdata == 8'h00) else $error("uv not cleared");
  write_back_a: assert property ((regWrite && (regAddr == 8'h03 || regAddr == 8'h04))
    ##1 !regWrite ##1 (regRead && !regWrite && regAddr == $past(regAddr, 2))
    |=> regRdata == $past(regWdata, 3)) else $error("read back differs");
  cover property (regRead && regAddr == 8'h05);
  cover property ($rose(resetPinOe));
  cover property (comparatorPower.ovUvPower == 7'h00);
endmodule : voltage_monitor_status_map_chk
bind voltage_monitor_status_map voltage_monitor_status_map_chk i_chk (.*);

// File: tb/voltage_monitor_status_map_test.sv
// Self-checking bench for the monitor status map.
`timescale 1ns/1ps
module voltage_monitor_status_map_test;
  import voltage_monitor_pkg::*;
  logic mclk = 0, resetn = 0, regWrite = 0, regRead = 0, oscTick = 0, oscRun = 1;
  logic parityError = 0, supplyGood = 0, ready = 0, enA = 1, enB = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, model[8];
  logic [1:0] holdSel = 2'h0;
  logic resetPinIn, resetPinOut, resetPinOe;
  comparator_t cmp = '0;
  comparator_power_t pwr;
  int bad_count = 0, n_tests = 0, k, c, a;
  // Clock and an oscillator tick that runs while oscRun is set.
  always #2.5 mclk = ~mclk;
  always #25 if (oscRun) oscTick = ~oscTick;
  voltage_monitor_status_map #(.HOLD_6US_CYCLES(20), .HOLD_8MS_CYCLES(30),
    .HOLD_16MS_CYCLES(40), .HOLD_32MS_CYCLES(50), .BUILTIN_SELF_TEST_TIME(50)) i_dut (
    .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .comparators(cmp),
    .comparatorPower(pwr), .oscTick(oscTick), .parityError(parityError),
    .supplyGood(supplyGood), .holdSelect(holdSel), .sequenceRecordReady(ready),
    .sequenceEnableA(enA), .sequenceEnableB(enB), .resetPinIn(resetPinIn),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));
  reset_pin_partner i_pin (.resetPinOe(resetPinOe), .resetPinOut(resetPinOut),
    .resetPinIn(resetPinIn));
  // Bench helpers.
  task automatic check(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr(logic [7:0] ad, logic [7:0] d);
    regAddr = ad;
    regWdata = d;
    regWrite = 1;
    step(1);
    regWrite = 0;
    step(1);
    if (ad == 8'h03 || ad == 8'h04) model[ad] = d;
  endtask : wr
  task automatic rd(logic [7:0] ad, logic [7:0] e, logic [7:0] m = 8'hFF);
    regAddr = ad;
    regRead = 1;
    step(1);
    regRead = 0;
    check($sformatf("reg%h", ad), e, regRdata & m);
    step(1);
  endtask : rd
  task automatic waitOe(logic v, output int n);
    n = 0;
    while (resetPinOe !== v) begin
      step(1);
      n++;
      if (n > 300) begin
        bad_count++;
        summarize();
      end
    end
  endtask : waitOe
  task automatic summarize();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  // Main sequence.
  initial begin
    void'($urandom(32'hC40F));
    model[3] = 8'h7F;
    model[4] = 8'h7F;
    step(12);
    resetn = 1;
    step(3);
    supplyGood = 1;
    rd(8'h03, model[3]);
    rd(8'h04, model[4]);
    repeat (4) begin
      wr(8'h03, 8'($urandom));
      rd(8'h03, model[3]);
      wr(8'h04, 8'($urandom));
      rd(8'h04, model[4]);
    end
    wr(8'h02, 8'hFF);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    wr(8'h03, 8'h7F);
    wr(8'h04, 8'h7F);
    check("offPower", 8'h7F, {1'b0, pwr.offPower});
    repeat (3) begin
      cmp.belowOff = 7'($urandom);
      step(3);
      rd(8'h07, {1'b0, cmp.belowOff});
    end
    cmp.belowOff = 7'h00;
    for (a = 5; a < 7; a++) begin
      c = $urandom_range(6);
      if (a == 5) cmp.overVoltage = 7'h01 << c;
      else cmp.underVoltage = 7'h01 << c;
      step(1);
      cmp.overVoltage = 7'h00;
      cmp.underVoltage = 7'h00;
      step(4);
      rd(8'(a), 8'h01 << c);
      rd(8'(a), 8'h00);
      waitOe(0, c);
    end
    for (k = 0; k < 4; k++) begin
      {enA, enB} = 2'(k);
      step(6);
      rd(8'h02, {4'h1, enB, enA, 2'h0});
    end
    parityError = 1;
    step(6);
    rd(8'h02, 8'h5C);
    wr(8'h04, 8'hFF);
    waitOe(1, c);
    step(6);
    rd(8'h02, 8'h6C);
    parityError = 0;
    wr(8'h04, 8'h3F);
    waitOe(0, c);
    cmp.underVoltage = 7'h40;
    step(10);
    check("unmapped oe", 8'h00, {7'h00, resetPinOe});
    cmp.underVoltage = 7'h00;
    rd(8'h06, 8'h40);
    wr(8'h04, 8'h7F);
    for (k = 0; k < 4; k++) begin
      holdSel = 2'(k);
      cmp.underVoltage = 7'h40;
      waitOe(1, c);
      cmp.underVoltage = 7'h00;
      rd(8'h06, 8'h40);
      waitOe(0, c);
      check("hold ok", 8'h01, {7'h00, c + 2 >= 20 + 10 * k && c + 2 <= 26 + 10 * k});
    end
    oscRun = 0;
    step(2020);
    rd(8'h02, 8'h80, 8'h80);
    oscRun = 1;
    step(40);
    rd(8'h02, 8'h00, 8'h80);
    for (k = 0; k < 2; k++) begin
      cmp.ovBistFail = k ? 7'h00 : 7'h10;
      cmp.uvBistFail = k ? 7'h02 : 7'h00;
      supplyGood = 0;
      step(4);
      supplyGood = 1;
      step(80);
      rd(8'h02, k ? 8'h01 : 8'h02, 8'h03);
    end
    wr(8'h03, 8'hFF);
    ready = 1;
    enA = 0;
    step(6);
    check("ovUvPower", 8'h00, {1'b0, pwr.ovUvPower});
    check("offPower off", 8'h00, {1'b0, pwr.offPower});
    enA = 1;
    step(6);
    check("offPower", 8'h7F, {1'b0, pwr.offPower});
    summarize();
  end
endmodule : voltage_monitor_status_map_test

// File: verilog/voltage_monitor_cfg.svh
// Register offsets, field positions, reset values and timing counts of the monitor status map.
`ifndef VOLTAGE_MONITOR_CFG_SVH
`define VOLTAGE_MONITOR_CFG_SVH
`define HEALTH_OFFSET 8'h02
`define MON_ENABLE_OFFSET 8'h03
`define RESET_MAP_OFFSET 8'h04
`define OV_STATUS_OFFSET 8'h05
`define UV_STATUS_OFFSET 8'h06
`define OFF_STATUS_OFFSET 8'h07
`define OSC_FAULT_BIT 7
`define PARITY_FAULT_BIT 6
`define INTERNAL_FAULT_BIT 5
`define RESET_LEVEL_BIT 4
`define SEQ_B_BIT 3
`define SEQ_A_BIT 2
`define OV_BUILTIN_SELF_TEST_BIT 1
`define UV_BUILTIN_SELF_TEST_BIT 0
`define POWER_DOWN_BIT 7
`define PARITY_MAP_BIT 7
`define MON_ENABLE_RESET 8'h7F
`define RESET_MAP_RESET 8'h7F
`define CLK_MHZ 200
`define OSC_MIN_KHZ 100
`define OSC_WINDOW_CYCLES ((`CLK_MHZ * 1000) / `OSC_MIN_KHZ)
`define BUILTIN_SELF_TEST_TIME_NS 72200
`define BUILTIN_SELF_TEST_CYCLES ((`BUILTIN_SELF_TEST_TIME_NS * `CLK_MHZ) / 1000)
`define HOLD_6US_NS 6000
`define HOLD_8MS_NS 8000000
`define HOLD_16MS_NS 16000000
`define HOLD_32MS_NS 32000000
`endif

// File: verilog/voltage_monitor_pkg.sv
// Types shared by the voltage monitor status map.
package voltage_monitor_pkg;
  typedef struct packed {
    logic [6:0] overVoltage;
    logic [6:0] underVoltage;
    logic [6:0] belowOff;
    logic [6:0] ovBistFail;
    logic [6:0] uvBistFail;
  } comparator_t;
  typedef struct packed {
    logic [6:0] ovUvPower;
    logic [6:0] offPower;
  } comparator_power_t;
  typedef enum logic [2:0] {
    BUILTIN_SELF_TEST_IDLE = 3'b001,
    BUILTIN_SELF_TEST_RUN = 3'b010,
    BUILTIN_SELF_TEST_DONE = 3'b100
  } builtin_self_test_state_t;
endpackage : voltage_monitor_pkg

// File: verilog/voltage_monitor_status_map.sv
// Status and control register bank of a seven-channel voltage supervisor.
// Summary of operation
// - Oscillator-fault bit 7 set when internal oscillator stops or runs below 50 kHz.
// - Parity-fault bit 6 set while any read/write register fails parity.
// - Internal fault bit 5 set whenever some condition drives reset low.
// - Bit 4 reads back the actual reset pin level.
// - Bits 3 and 2 read back the live sequence-enable pin levels.
// - Bit 1 set when any overvoltage comparator fails self-test.
// - Power-down set, enable-a low, recording ready: all comparators switch off.
// - Rising edge of enable-a lifts the latch: enabled OFF comparators come back on, OV/UV ones only while recording is ready.
// - Power-down clear keeps OFF comparators on; OV/UV powered as needed.
// - Seven channel enable bits enable each channel's OV/UV monitoring.
// - Parity-to-reset bit decides whether parity faults assert reset.
// - Seven mapping bits decide whether channel OV/UV faults assert reset.
// - Overvoltage status bits latch; reading the register clears all bits.
// - Undervoltage status bits latch; reading the register clears all bits.
// - OFF statuses are live, unlatched comparator outputs.
// - OFF status reads one below the OFF threshold, zero above.
// - Reset held low for selectable 6 us, 8, 16 or 32 ms after faults clear.
// - Self-test starts after supply rises, ends within 72.2 us, sets result bits.
// - OFF comparator powered if enabled, not latched off, and power-down off, enable-a high or ready.
`timescale 1ns/1ps
`include "voltage_monitor_cfg.svh"
module voltage_monitor_status_map
  import voltage_monitor_pkg::*;
#(
  parameter int HOLD_6US_CYCLES = (`HOLD_6US_NS * `CLK_MHZ) / 1000,
  parameter int HOLD_8MS_CYCLES = (`HOLD_8MS_NS / 1000) * `CLK_MHZ,
  parameter int HOLD_16MS_CYCLES = (`HOLD_16MS_NS / 1000) * `CLK_MHZ,
  parameter int HOLD_32MS_CYCLES = (`HOLD_32MS_NS / 1000) * `CLK_MHZ,
  parameter int OSC_WINDOW = `OSC_WINDOW_CYCLES,
  parameter int BUILTIN_SELF_TEST_TIME = `BUILTIN_SELF_TEST_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic resetn,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Analog front end and internal health.
  input wire comparator_t comparators,
  output comparator_power_t comparatorPower,
  input wire logic oscTick,
  input wire logic parityError,
  input wire logic supplyGood,
  input wire logic [1:0] holdSelect,
  input wire logic sequenceRecordReady,
  // Pins.
  input wire logic sequenceEnableA,
  input wire logic sequenceEnableB,
  input wire logic resetPinIn,
  output logic resetPinOut,
  output logic resetPinOe
);

  // Reset release and pin synchronisers.
  logic [1:0] rstSync;
  logic rstn;
  logic [2:0] enASync;
  logic [2:0] enBSync;
  logic [2:0] rstPinSync;
  logic [2:0] tickSync;
  logic enAState;
  logic enBState;
  logic rstPinState;
  logic tickState;
  logic enARise;

  // Host-written control registers.
  logic [7:0] monEnable_reg;
  logic [7:0] resetMap_reg;

  // Latched comparator events.
  logic [6:0] ovStatus_reg;
  logic [6:0] uvStatus_reg;
  logic [6:0] ovStatus_next;
  logic [6:0] uvStatus_next;

  // Power-down state.
  logic powerDownLatch_reg;

  // Oscillator watchdog.
  logic [31:0] oscCount_reg;
  logic oscFault_reg;

  // Self-test sequencer.
  builtin_self_test_state_t bistState_reg;
  logic [31:0] bistCount_reg;
  logic ovBist_reg;
  logic uvBist_reg;

  // Reset pin hold timer and fault gathering.
  logic [31:0] holdCount_reg;
  logic [31:0] holdLimit;
  logic faultActive;
  logic [6:0] chanFault;

  // Read path.
  logic [7:0] health;
  logic [7:0] rdata_next;

  // Reset release through two flip-flops.
  // Assertion stays asynchronous so the outputs go safe at once; release is
  // synchronised so that no flop leaves reset on a different edge.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstn = rstSync[1];

  // Pin inputs pass three flip-flops; a change counts when the last two agree.
  // The first stage may go metastable, so only the second stage reads it.
  // Waiting for two agreeing samples drops a glitch shorter than a cycle.
  // The reset pin copy starts high to match its pull-up, so no false low
  // level is reported right after reset.
  // The oscillator tick is filtered the same way before its edges are counted.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enASync <= 3'h0;
      enBSync <= 3'h0;
      rstPinSync <= 3'h7;
      tickSync <= 3'h0;
      enAState <= 1'b0;
      enBState <= 1'b0;
      rstPinState <= 1'b1;
      tickState <= 1'b0;
    end else begin
      enASync <= {enASync[1:0], sequenceEnableA};
      enBSync <= {enBSync[1:0], sequenceEnableB};
      rstPinSync <= {rstPinSync[1:0], resetPinIn};
      tickSync <= {tickSync[1:0], oscTick};
      if (enASync[2] == enASync[1]) enAState <= enASync[2];
      if (enBSync[2] == enBSync[1]) enBState <= enBSync[2];
      if (rstPinSync[2] == rstPinSync[1]) rstPinState <= rstPinSync[2];
      if (tickSync[2] == tickSync[1]) tickState <= tickSync[2];
    end
  end
  // Rising edge of enable-a, seen in the cycle its filtered level changes.
  assign enARise = (enASync[2] == enASync[1]) && enASync[2] && !enAState;

  // Software-written control registers.
  // Writes to read-only or unmapped offsets are dropped here; only these two
  // registers hold host data.
  // Reset values enable every channel and map every channel fault to the pin.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      monEnable_reg <= `MON_ENABLE_RESET;
      resetMap_reg <= `RESET_MAP_RESET;
    end else if (regWrite) begin
      if (regAddr == `MON_ENABLE_OFFSET) monEnable_reg <= regWdata;
      if (regAddr == `RESET_MAP_OFFSET) resetMap_reg <= regWdata;
    end
  end

  // Power-down latch: entered when conditions hold, left on enable-a rising edge.
  // Leaving wins over entry, so a pin that rises in the cycle in which
  // recording finishes keeps the comparators alive.
  // Clearing the power-down bit also releases the latch at once.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      powerDownLatch_reg <= 1'b0;
    end else if (enARise || !monEnable_reg[`POWER_DOWN_BIT]) begin
      powerDownLatch_reg <= 1'b0;
    end else if (!enAState && sequenceRecordReady) begin
      powerDownLatch_reg <= 1'b1;
    end
  end

  // Comparator power per channel.
  // The latch cuts every comparator. Otherwise OFF comparators stay on unless
  // power-down is armed with enable-a low and recording not ready.
  // OV/UV comparators run only while the input is above its OFF threshold,
  // or, with power-down armed, while shutdown recording is ready.
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      comparatorPower.offPower[i] = monEnable_reg[i] && !powerDownLatch_reg
        && (!monEnable_reg[`POWER_DOWN_BIT] || enAState || sequenceRecordReady);
      comparatorPower.ovUvPower[i] = monEnable_reg[i] && !powerDownLatch_reg
        && (monEnable_reg[`POWER_DOWN_BIT] ? sequenceRecordReady
                                           : !comparators.belowOff[i]);
    end
  end

  // Latched OV/UV status; a new event wins over the clearing read.
  // Events are taken only from powered comparators, so a disabled channel
  // cannot raise a stale status bit.
  // The read clears all bits at once, as the host sees the whole word.
  always_comb begin
    ovStatus_next = ovStatus_reg;
    uvStatus_next = uvStatus_reg;
    if (regRead && regAddr == `OV_STATUS_OFFSET) ovStatus_next = 7'h00;
    if (regRead && regAddr == `UV_STATUS_OFFSET) uvStatus_next = 7'h00;
    ovStatus_next = ovStatus_next | (comparators.overVoltage & comparatorPower.ovUvPower);
    uvStatus_next = uvStatus_next | (comparators.underVoltage & comparatorPower.ovUvPower);
  end

  // Status registers take the merged clear and set.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovStatus_reg <= 7'h00;
      uvStatus_reg <= 7'h00;
    end else begin
      ovStatus_reg <= ovStatus_next;
      uvStatus_reg <= uvStatus_next;
    end
  end

  // Oscillator watchdog: a window without a tick edge flags a fault.
  // The counter stops at the window so the fault holds until the next tick
  // edge; a window shorter than half a tick period would flag falsely.
  // Both tick edges count, so a stuck-high tick is caught as well.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oscCount_reg <= 32'h0;
      oscFault_reg <= 1'b0;
    end else if (tickState != tickSync[2] && tickSync[2] == tickSync[1]) begin
      oscCount_reg <= 32'h0;
      oscFault_reg <= 1'b0;
    end else if (oscCount_reg >= 32'(OSC_WINDOW)) begin
      oscFault_reg <= 1'b1;
    end else begin
      oscCount_reg <= oscCount_reg + 32'h1;
    end
  end

  // Self-test sequencer: one run for each rise of supply good.
  // A supply drop returns it to idle so the next rise tests again, even in
  // mid-run; the results of the last finished run stay readable meanwhile.
  // Results are taken on the final count, never from a half-finished test.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bistState_reg <= BUILTIN_SELF_TEST_IDLE;
      bistCount_reg <= 32'h0;
      ovBist_reg <= 1'b0;
      uvBist_reg <= 1'b0;
    end else if (!supplyGood) begin
      bistState_reg <= BUILTIN_SELF_TEST_IDLE;
      bistCount_reg <= 32'h0;
    end else begin
      case (bistState_reg)
        BUILTIN_SELF_TEST_IDLE: begin
          if (supplyGood) bistState_reg <= BUILTIN_SELF_TEST_RUN;
        end
        BUILTIN_SELF_TEST_RUN: begin
          bistCount_reg <= bistCount_reg + 32'h1;
          if (bistCount_reg >= 32'(BUILTIN_SELF_TEST_TIME - 1)) begin
            ovBist_reg <= |comparators.ovBistFail;
            uvBist_reg <= |comparators.uvBistFail;
            bistState_reg <= BUILTIN_SELF_TEST_DONE;
          end
        end
        BUILTIN_SELF_TEST_DONE: begin
          bistState_reg <= BUILTIN_SELF_TEST_DONE;
        end
        default: begin
          bistState_reg <= BUILTIN_SELF_TEST_IDLE;
        end
      endcase
    end
  end

  // Fault gathering and reset hold timer.
  // A parity fault reaches the pin only when its mapping bit is set; an
  // unmapped channel still latches status for the host to read.
  // Channel faults come from the latched status, so a short event still
  // pulls the pin until the host has read and cleared it.
  assign chanFault = (ovStatus_reg | uvStatus_reg) & resetMap_reg[6:0];
  assign faultActive = (|chanFault)
    || (parityError && resetMap_reg[`PARITY_MAP_BIT]);

  // Hold length chosen by the two select bits.
  always_comb begin
    case (holdSelect)
      2'h0: holdLimit = 32'(HOLD_6US_CYCLES);
      2'h1: holdLimit = 32'(HOLD_8MS_CYCLES);
      2'h2: holdLimit = 32'(HOLD_16MS_CYCLES);
      default: holdLimit = 32'(HOLD_32MS_CYCLES);
    endcase
  end

  // Reload while any fault stands, then count down to release the pin.
  // A fault that returns during the hold restarts the full timeout.
  // A select change during the hold takes effect at the next reload only.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      holdCount_reg <= 32'h0;
    end else if (faultActive) begin
      holdCount_reg <= holdLimit;
    end else if (holdCount_reg != 32'h0) begin
      holdCount_reg <= holdCount_reg - 32'h1;
    end
  end

  // Open-drain reset: pull low while a fault or its hold time lasts.
  // The pin only sinks; the pull-up gives the high level, so a shorted or
  // open pin shows as a mismatch between the fault flag and the read-back.
  // The drive enable is combinational so a new fault reaches the pin at once.
  assign resetPinOut = 1'b0;
  assign resetPinOe = faultActive || (holdCount_reg != 32'h0);

  // Health status word.
  // Parity and internal fault bits are live levels; the read copy is taken
  // on the read strobe.
  // Bit 5 follows the pin drive itself, so it is normally the inverse of the
  // read-back level in bit 4.
  always_comb begin
    health = 8'h00;
    health[`OSC_FAULT_BIT] = oscFault_reg;
    health[`PARITY_FAULT_BIT] = parityError;
    health[`INTERNAL_FAULT_BIT] = resetPinOe;
    health[`RESET_LEVEL_BIT] = rstPinState;
    health[`SEQ_B_BIT] = enBState;
    health[`SEQ_A_BIT] = enAState;
    health[`OV_BUILTIN_SELF_TEST_BIT] = ovBist_reg;
    health[`UV_BUILTIN_SELF_TEST_BIT] = uvBist_reg;
  end

  // Read mux; unmapped addresses read zero.
  // Reserved bit 7 of the status words reads zero.
  always_comb begin
    case (regAddr)
      `HEALTH_OFFSET: rdata_next = health;
      `MON_ENABLE_OFFSET: rdata_next = monEnable_reg;
      `RESET_MAP_OFFSET: rdata_next = resetMap_reg;
      `OV_STATUS_OFFSET: rdata_next = {1'b0, ovStatus_reg};
      `UV_STATUS_OFFSET: rdata_next = {1'b0, uvStatus_reg};
      `OFF_STATUS_OFFSET: rdata_next = {1'b0, comparators.belowOff};
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data register, loaded on a read strobe.
  // Holding the last value between reads keeps the host's sample stable.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= rdata_next;
    end
  end

endmodule : voltage_monitor_status_map
